// *** rtl/dca_defs.vh ***
// Offsets, field positions, reset values and counts of the DMA arbiter block.
`ifndef DCA_DEFS_VH
`define DCA_DEFS_VH
`define DCA_NCH         6
`define DCA_A_PRIO_EN   12'h000
`define DCA_A_STATUS    12'h004
`define DCA_A_DONE      12'h008
`define DCA_CH_BASE_LO  3'h1
`define DCA_CH_BASE_HI  3'h6
`define DCA_R_SRC       3'h0
`define DCA_R_DST       3'h1
`define DCA_R_CNT       3'h2
`define DCA_R_SFC       3'h3
`define DCA_R_MODE      3'h4
`define DCA_EN_MSB      5
`define DCA_EN_LSB      0
`define DCA_PRI_MSB     13
`define DCA_PRI_LSB     8
`define DCA_FREE_BIT    15
`define DCA_SYN_MSB     15
`define DCA_SYN_LSB     12
`define DCA_DBL_BIT     11
`define DCA_FC_MSB      7
`define DCA_FC_LSB      0
`define DCA_SFC_WMASK   16'hf8ff
`define DCA_SFC_RST     16'h0000
`define DCA_REG_RST     16'h0000
`define DCA_SYN_NONE    4'h0
`define DCA_MODE_ABU    0
`endif

// *** rtl/dca_arb.v ***
// Two-level round-robin arbiter for the six DMA channels.
`include "dca_defs.vh"
module dca_arb (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [5:0] req,
    input  wire [5:0] prio,
    input  wire       adv,
    output reg        gnt_vld,
    output reg  [2:0] gnt_idx
);
    reg  [2:0] hi_ptr_q;
    reg  [2:0] lo_ptr_q;
    reg  [3:0] hi_pick;
    reg  [3:0] lo_pick;

    function [2:0] dca_next;
        input [2:0] x;
        begin
            dca_next = (x == 3'h5) ? 3'h0 : x + 3'h1;
        end
    endfunction

    // Scan starts at the pointer, so the channel after the last winner
    // is looked at first.
    function [3:0] dca_pick;
        input [5:0] m;
        input [2:0] p;
        integer     k;
        reg   [2:0] j;
        reg         f;
        begin
            dca_pick = 4'h0;
            f = 1'b0;
            j = p;
            for (k = 0; k < `DCA_NCH; k = k + 1) begin
                if (!f && m[j]) begin
                    f = 1'b1;
                    dca_pick = {1'b1, j};
                end
                j = dca_next(j);
            end
        end
    endfunction

    always @* begin
        hi_pick = dca_pick(req & prio, hi_ptr_q);
        lo_pick = dca_pick(req & ~prio, lo_ptr_q);
        if (hi_pick[3]) begin
            gnt_vld = 1'b1;
            gnt_idx = hi_pick[2:0];
        end else begin
            gnt_vld = lo_pick[3];
            gnt_idx = lo_pick[2:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_ptr_q <= 3'h0;
            lo_ptr_q <= 3'h0;
        end else if (adv && gnt_vld) begin
            if (hi_pick[3]) begin
                hi_ptr_q <= dca_next(gnt_idx);
            end else begin
                lo_ptr_q <= dca_next(gnt_idx);
            end
        end
    end
endmodule

// *** rtl/dca_top.v ***
// Six-channel DMA arbiter and channel context registers behind APB.
`include "dca_defs.vh"
module dca_top (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        emu_halt,
    input  wire [15:0] sync_evt,
    output reg         mem_req,
    output reg         mem_we,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    input  wire        mem_ack
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_RD   = 4'b0010;
    localparam [3:0] S_WR   = 4'b0100;
    localparam [3:0] S_UPD  = 4'b1000;

    reg  [15:0] src_q [0:5];
    reg  [15:0] dst_q [0:5];
    reg  [15:0] cnt_q [0:5];
    reg  [15:0] shd_q [0:5];
    reg  [15:0] sfc_q [0:5];
    reg  [5:0]  abu_q;
    reg  [5:0]  en_q;
    reg  [5:0]  pri_q;
    reg         free_q;
    reg  [5:0]  done_q;
    reg  [5:0]  pend_q;
    reg  [15:0] syn1_q;
    reg  [15:0] syn2_q;
    reg  [15:0] syn3_q;
    reg         halt1_q;
    reg         halt2_q;
    reg  [3:0]  st_q;
    reg  [2:0]  cur_q;
    reg         word2_q;

    reg  [2:0]  dch;
    reg  [2:0]  dreg;
    reg         dchan;
    reg         dglob;
    reg         dstat;
    reg         ddone;
    reg         dok;
    reg  [15:0] rd_val;
    reg  [5:0]  req;
    reg  [5:0]  start_v;
    reg  [5:0]  upd_v;

    wire        gnt_vld;
    wire [2:0]  gnt_idx;
    wire        acc_req = psel & penable & ~pready;
    wire        wr      = psel & penable & pready & pwrite & dok;
    wire        run     = ~(halt2_q & ~free_q);
    wire        start   = st_q[0] & gnt_vld & run;
    wire [15:0] edge_v  = syn2_q & ~syn3_q;
    wire [15:0] cur_sfc = sfc_q[cur_q];
    wire [15:0] cur_cnt = cnt_q[cur_q];
    wire [15:0] cur_src = src_q[cur_q];
    wire [15:0] cur_dst = dst_q[cur_q];
    wire        cur_dbl = cur_sfc[`DCA_DBL_BIT];
    wire        frm_end = st_q[3] & ~abu_q[cur_q] & (cur_cnt == 16'h0);
    wire        blk_end = frm_end & (cur_sfc[`DCA_FC_MSB:`DCA_FC_LSB] == 8'h0);
    wire [5:0]  done_v  = upd_v & {6{blk_end}};
    wire        wr_glob = wr & dglob;

    // Each element advances the addresses by its own size in words.
    function [15:0] dca_step;
        input dbl;
        begin
            dca_step = dbl ? 16'h0002 : 16'h0001;
        end
    endfunction

    dca_arb dca_arb_i (
        .clk     (clk),
        .rst_n   (rst_n),
        .req     (req),
        .prio    (pri_q),
        .adv     (start),
        .gnt_vld (gnt_vld),
        .gnt_idx (gnt_idx)
    );

    always @* begin
        dch   = paddr[7:5] - 3'h1;
        dreg  = paddr[4:2];
        dchan = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) &&
                (paddr[7:5] >= `DCA_CH_BASE_LO) &&
                (paddr[7:5] <= `DCA_CH_BASE_HI) &&
                (paddr[4:2] <= `DCA_R_MODE);
        dglob = (paddr == `DCA_A_PRIO_EN);
        dstat = (paddr == `DCA_A_STATUS);
        ddone = (paddr == `DCA_A_DONE);
        dok   = dchan | dglob | dstat | ddone;
    end

    always @* begin
        rd_val = 16'h0;
        if (dglob) begin
            rd_val[`DCA_EN_MSB:`DCA_EN_LSB]   = en_q;
            rd_val[`DCA_PRI_MSB:`DCA_PRI_LSB] = pri_q;
            rd_val[`DCA_FREE_BIT]             = free_q;
        end else if (dstat) begin
            rd_val = {2'h0, pend_q, 1'b0, cur_q, 3'h0, ~st_q[0]};
        end else if (ddone) begin
            rd_val = {10'h0, done_q};
        end else if (dchan) begin
            case (dreg)
                `DCA_R_SRC:  rd_val = src_q[dch];
                `DCA_R_DST:  rd_val = dst_q[dch];
                `DCA_R_CNT:  rd_val = cnt_q[dch];
                `DCA_R_SFC:  rd_val = sfc_q[dch];
                `DCA_R_MODE: rd_val = {15'h0, abu_q[dch]};
                default:     rd_val = 16'h0;
            endcase
        end
    end

    always @* begin : req_decode
        integer i;
        i = 0;
        for (i = 0; i < `DCA_NCH; i = i + 1) begin
            // Zero in the sync field needs no event at all.
            req[i] = en_q[i] &
                     ((sfc_q[i][`DCA_SYN_MSB:`DCA_SYN_LSB] ==
                       `DCA_SYN_NONE) | pend_q[i]);
            start_v[i] = start & (gnt_idx == i[2:0]);
            upd_v[i]   = st_q[3] & (cur_q == i[2:0]);
        end
    end

    // One wait state lets the read data come from a flip-flop.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc_req;
            pslverr <= acc_req & ~dok;
            prdata  <= (acc_req & ~pwrite) ? {16'h0, rd_val} : 32'h0;
        end
    end

    // Sync pins and the halt pin cross in from outside the clock domain.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syn1_q  <= 16'h0;
            syn2_q  <= 16'h0;
            syn3_q  <= 16'h0;
            halt1_q <= 1'b0;
            halt2_q <= 1'b0;
        end else begin
            syn1_q  <= sync_evt;
            syn2_q  <= syn1_q;
            syn3_q  <= syn2_q;
            halt1_q <= emu_halt;
            halt2_q <= halt1_q;
        end
    end

    // A sync edge in the cycle its element starts is kept for the next one.
    always @(posedge clk or negedge rst_n) begin : pend_regs
        integer i;
        if (!rst_n) begin
            pend_q <= 6'h0;
        end else begin
            for (i = 0; i < `DCA_NCH; i = i + 1) begin
                pend_q[i] <= ((sfc_q[i][`DCA_SYN_MSB:`DCA_SYN_LSB] !=
                               `DCA_SYN_NONE) &
                              edge_v[sfc_q[i][`DCA_SYN_MSB:`DCA_SYN_LSB]]) |
                             (pend_q[i] & ~start_v[i]);
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q   <= 6'h0;
            pri_q  <= 6'h0;
            free_q <= 1'b0;
            done_q <= 6'h0;
        end else begin
            if (wr_glob) begin
                pri_q  <= pwdata[`DCA_PRI_MSB:`DCA_PRI_LSB];
                free_q <= pwdata[`DCA_FREE_BIT];
            end
            en_q <= (wr_glob ? pwdata[`DCA_EN_MSB:`DCA_EN_LSB] : en_q) &
                    ~done_v;
            done_q <= done_v |
                      (done_q & ~((wr & ddone) ? pwdata[5:0] : 6'h0));
        end
    end

    always @(posedge clk or negedge rst_n) begin : ctx_regs
        integer i;
        if (!rst_n) begin
            for (i = 0; i < `DCA_NCH; i = i + 1) begin
                src_q[i] <= `DCA_REG_RST;
                dst_q[i] <= `DCA_REG_RST;
                cnt_q[i] <= `DCA_REG_RST;
                shd_q[i] <= `DCA_REG_RST;
                sfc_q[i] <= `DCA_SFC_RST;
            end
            abu_q <= 6'h0;
        end else begin
            for (i = 0; i < `DCA_NCH; i = i + 1) begin
                if (wr && dchan && dch == i[2:0] && dreg == `DCA_R_SRC) begin
                    src_q[i] <= pwdata[15:0];
                end else if (upd_v[i]) begin
                    src_q[i] <= src_q[i] + dca_step(cur_dbl);
                end
                if (wr && dchan && dch == i[2:0] && dreg == `DCA_R_DST) begin
                    dst_q[i] <= pwdata[15:0];
                end else if (upd_v[i]) begin
                    dst_q[i] <= dst_q[i] + dca_step(cur_dbl);
                end
                if (wr && dchan && dch == i[2:0] && dreg == `DCA_R_CNT) begin
                    cnt_q[i] <= pwdata[15:0];
                    shd_q[i] <= pwdata[15:0];
                end else if (upd_v[i] && !abu_q[i]) begin
                    if (cnt_q[i] == 16'h0) begin
                        cnt_q[i] <= shd_q[i];
                    end else begin
                        cnt_q[i] <= cnt_q[i] - 16'h1;
                    end
                end
                if (wr && dchan && dch == i[2:0] && dreg == `DCA_R_SFC) begin
                    sfc_q[i] <= pwdata[15:0] & `DCA_SFC_WMASK;
                end else if (upd_v[i] && frm_end && !blk_end) begin
                    sfc_q[i][`DCA_FC_MSB:`DCA_FC_LSB] <=
                        sfc_q[i][`DCA_FC_MSB:`DCA_FC_LSB] - 8'h1;
                end
                if (wr && dchan && dch == i[2:0] && dreg == `DCA_R_MODE) begin
                    abu_q[i] <= pwdata[`DCA_MODE_ABU];
                end
            end
        end
    end

    // The halt only blocks new elements, so memory never sees a torn pair.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= S_IDLE;
            cur_q     <= 3'h0;
            word2_q   <= 1'b0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 16'h0;
            mem_wdata <= 16'h0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        cur_q    <= gnt_idx;
                        word2_q  <= 1'b0;
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_addr <= src_q[gnt_idx];
                        st_q     <= S_RD;
                    end
                end
                S_RD: begin
                    if (mem_ack) begin
                        mem_we    <= 1'b1;
                        mem_wdata <= mem_rdata;
                        mem_addr  <= {cur_dst[15:1],
                                      cur_dst[0] ^ word2_q};
                        st_q      <= S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack) begin
                        if (cur_dbl && !word2_q) begin
                            word2_q  <= 1'b1;
                            mem_we   <= 1'b0;
                            mem_addr <= {cur_src[15:1], ~cur_src[0]};
                            st_q     <= S_RD;
                        end else begin
                            mem_req <= 1'b0;
                            mem_we  <= 1'b0;
                            st_q    <= S_UPD;
                        end
                    end
                end
                S_UPD: begin
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q    <= S_IDLE;
                    mem_req <= 1'b0;
                    mem_we  <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** bench/dca_top_properties.sv ***
// Concurrent checks on the register and memory ports of the DMA arbiter.
module dca_top_chk (
    input wire        clk,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        emu_halt,
    input wire [15:0] sync_evt,
    input wire        mem_req,
    input wire        mem_we,
    input wire [15:0] mem_addr,
    input wire [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire        mem_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    reg       free_q;
    reg [5:0] en_q;
    // Only CPU writes are mirrored; hardware clears can only add zeros.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            free_q <= 1'b0;
            en_q   <= 6'h00;
        end else if (psel && penable && pready && pwrite && paddr == 0) begin
            free_q <= pwdata[15];
            en_q   <= pwdata[5:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ready_pulse: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    chk_one_wait: assert property (
        $rose(psel && penable) |-> !pready ##1 pready)
        else $error("access phase not two cycles");
    chk_unmapped_err: assert property (
        pready && paddr == 12'h0e0 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (
        pready && paddr == 12'h000 |-> !pslverr)
        else $error("mapped access refused");
    chk_read_idle: assert property (
        !pready |-> prdata == 32'h0) else $error("prdata outside answer");
    chk_mem_hold: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata)) else $error("mem unheld");
    chk_read_write: assert property (
        mem_req && mem_ack && !mem_we |=> mem_req && mem_we
        && mem_wdata == $past(mem_rdata)) else $error("read not copied");
    chk_halt_hold: assert property (
        (emu_halt && !free_q) [*6] |-> !$rose(mem_req))
        else $error("element started under halt");
    chk_enable_gate: assert property (
        (en_q == 6'h00) [*3] |-> !$rose(mem_req))
        else $error("element started with no channel enabled");
    cover property (mem_req && mem_ack && mem_we);
    cover property (pready && pslverr);
    cover property (emu_halt && free_q && mem_req);
endmodule

// *** bench/dca_mem.sv ***
// Behavioural memory on the transfer side, prompt or with three waits.
module dca_mem (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         slow,
    input  wire         mem_req,
    input  wire         mem_we,
    input  wire  [15:0] mem_addr,
    output logic [15:0] mem_rdata,
    output logic        mem_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0]  wait_q;
    logic [15:0] last_q;
    assign mem_ack = mem_req && (!slow || wait_q == 2'h3);
    // Outside a read the bus toggles, so stale data cannot pass unseen.
    assign mem_rdata = (mem_req && !mem_we) ? mem_addr ^ 16'ha5c3 : ~last_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 2'h0;
            last_q <= 16'h0000;
        end else begin
            wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
            last_q <= mem_rdata;
        end
    end
endmodule

// *** bench/tb_dca_top.sv ***
// Self-checking bench for the six-channel DMA arbiter block.
module tb_dca_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        emu_halt, slow, mem_req, mem_we, mem_ack, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] sync_evt, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] wq[$], rq[$];
    int          n_fail, compares;
    dca_top dca_top_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .emu_halt(emu_halt), .sync_evt(sync_evt), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    dca_mem dca_mem_i (.clk(clk), .rst_n(rst_n), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    always @(posedge clk) if (mem_req && mem_ack) begin
        if (mem_we) wq.push_back({mem_addr, mem_wdata});
        else rq.push_back({16'h0000, mem_addr});
    end
    task end_of_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input [31:0] x, input [31:0] g);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task bus(input bit w, input [11:0] a, input [15:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function [11:0] cb(input [2:0] c);
        cb = {4'h0, c + 3'h1, 5'h00};
    endfunction
    function [31:0] ex(input [15:0] dst, input [15:0] src);
        ex = {dst, src ^ 16'ha5c3};
    endfunction
    task cfg(input [2:0] c, input [15:0] s, dd, n, f);
        bus(1, cb(c), s);
        bus(1, cb(c) + 12'h4, dd);
        bus(1, cb(c) + 12'h8, n);
        bus(1, cb(c) + 12'hc, f);
        wq.delete();
        rq.delete();
    endtask
    task wait_wr(input int n);
        int k;
        k = 0;
        while (wq.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (wq.size() < n) chk("write count", n, wq.size());
    endtask
    task t_reset;
        bus(0, 12'h000, 0);
        chk("prio_en reset", 0, r);
        bus(0, cb(0) + 12'hc, 0);
        chk("sfc reset", 0, r);
        bus(1, cb(0) + 12'hc, 16'hffff);
        bus(0, cb(0) + 12'hc, 0);
        chk("sfc fields", 32'hf8ff, r);
        bus(0, 12'h0e0, 0);
        chk("unmapped err", 1, e);
    endtask
    task t_single;
        cfg(0, 16'h0100, 16'h0200, 0, 0);
        bus(1, 12'h000, 16'h0001);
        wait_wr(1);
        repeat (10) @(posedge clk);
        chk("one element", 1, wq.size());
        chk("element", ex(16'h0200, 16'h0100), wq[0]);
        bus(0, cb(0), 0);
        chk("src step", 32'h0101, r);
        bus(0, 12'h000, 0);
        chk("enable cleared", 0, r);
        bus(0, 12'h008, 0);
        chk("done set", 32'h0001, r);
        bus(1, 12'h008, 16'h0001);
        bus(0, 12'h008, 0);
        chk("done clear", 0, r);
        bus(0, 12'h004, 0);
        chk("status idle", 0, r);
    endtask
    task t_frames;
        slow <= 1'b1;
        cfg(0, 16'h0300, 16'h0400, 2, 1);
        bus(1, 12'h000, 16'h0001);
        wait_wr(6);
        repeat (30) @(posedge clk);
        chk("elements", 6, wq.size());
        chk("last dst", 32'h0405, wq[5][31:16]);
        bus(0, cb(0) + 12'h8, 0);
        chk("count reload", 2, r);
        slow <= 1'b0;
    endtask
    task t_prio;
        logic [15:0] pe [6];
        pe = '{16'h2100, 16'h2101, 16'h1100, 16'h3100, 16'h1101, 16'h3101};
        cfg(1, 16'h1000, 16'h1100, 1, 0);
        cfg(2, 16'h2000, 16'h2100, 1, 0);
        cfg(3, 16'h3000, 16'h3100, 1, 0);
        bus(1, 12'h000, 16'h040e);
        wait_wr(6);
        for (int i = 0; i < 6; i++) chk("order", pe[i], wq[i][31:16]);
    endtask
    task t_halt;
        @(posedge clk) emu_halt <= 1'b1;
        cfg(0, 16'h0500, 16'h0600, 0, 0);
        bus(1, 12'h000, 16'h0001);
        repeat (40) @(posedge clk);
        chk("halted", 0, wq.size());
        bus(1, 12'h000, 16'h8001);
        wait_wr(1);
        chk("free run", 1, wq.size());
        emu_halt <= 1'b0;
        bus(1, 12'h000, 0);
    endtask
    task t_dbl;
        cfg(4, 16'h0701, 16'h0800, 0, 16'h0800);
        bus(1, 12'h000, 16'h0010);
        wait_wr(2);
        chk("dbl first", ex(16'h0800, 16'h0701), wq[0]);
        chk("dbl second", ex(16'h0801, 16'h0700), wq[1]);
    endtask
    task t_sync;
        cfg(0, 16'h0900, 16'h0a00, 0, 16'h1000);
        bus(1, 12'h000, 16'h0001);
        repeat (30) @(posedge clk);
        chk("no event", 0, wq.size());
        sync_evt <= 16'h0002;
        repeat (3) @(posedge clk);
        sync_evt <= 16'h0000;
        wait_wr(1);
        chk("event element", ex(16'h0a00, 16'h0900), wq[0]);
    endtask
    task t_abu;
        cfg(5, 16'h0b00, 16'h0c00, 3, 0);
        bus(1, cb(5) + 12'h10, 16'h0001);
        bus(1, 12'h000, 16'h0020);
        wait_wr(5);
        bus(0, cb(5) + 12'h8, 0);
        chk("abu count", 3, r);
        bus(1, cb(5), 16'h0d00);
        wq.delete();
        rq.delete();
        wait_wr(4);
        chk("new src", 8'h0d, rq[2][15:8]);
        bus(1, 12'h000, 0);
        repeat (10) @(posedge clk);
        wq.delete();
        repeat (30) @(posedge clk);
        chk("disabled", 0, wq.size());
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500us;
        n_fail++;
        $display("MISMATCH watchdog expected end seen hang");
        end_of_test;
    end
    initial begin
        {rst_n, psel, penable, pwrite, emu_halt, slow} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        sync_evt = 16'h0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_single;
        t_frames;
        t_prio;
        t_halt;
        t_dbl;
        t_sync;
        t_abu;
        end_of_test;
    end
endmodule
bind dca_top dca_top_chk dca_top_chk_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emu_halt(emu_halt), .sync_evt(sync_evt), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
